// ===== rtl/bie_core.sv
// execution of absolute branch and the increment family in four phases
// program memory shows the word at O_PC and the word after it each cycle;
// data memory answers a read combinationally while O_DATA_RE is high
//
// Summary of operation
// [RULE1] branch loads 20-bit literal into pc 20:1
// [RULE2] branch decoded from two words, EF then F; the code decodes only the EF word and does not check the F
// [RULE3] branch takes two cycles, second is idle
// [RULE4] increment adds one and updates five flags
// [RULE5] destination bit picks working or file register
// [RULE6] bank bit picks access bank or bank select
// [RULE7] extended set, f at most 95: indexed addressing
// [RULE8] skip-if-zero discards next word, flags unchanged
// [RULE9] skip-if-nonzero discards next word, flags unchanged
// [RULE10] skip executes a no-operation in its place
// [RULE11] skipped two-word instruction costs two idle cycles
// [RULE12] decode, read, process, write in four phases
`timescale 1ns/1ps
module bie_core (
	// clock and reset
	input  wire logic                          I_CLK_SYS,
	input  wire logic                          I_RST,
	// program memory
	input  wire logic [bie_pkg::WORD_W-1:0]    I_INSTR_WORD,
	input  wire logic [bie_pkg::WORD_W-1:0]    I_NEXT_WORD,
	output logic      [bie_pkg::PC_W-1:0]      O_PC,
	// configuration
	input  wire logic                          I_EXT_ISA_EN,
	input  wire logic [bie_pkg::BSR_W-1:0]     I_BANK_SELECT,
	input  wire logic [bie_pkg::ADDR_W-1:0]    I_INDEX_BASE,
	// data memory
	output logic      [bie_pkg::ADDR_W-1:0]    O_DATA_ADDR,
	output logic                               O_DATA_RE,
	input  wire logic [bie_pkg::DATA_W-1:0]    I_DATA_RDATA,
	output logic                               O_DATA_WE,
	output logic      [bie_pkg::DATA_W-1:0]    O_DATA_WDATA,
	// working register
	output logic                               O_W_WE,
	output logic      [bie_pkg::DATA_W-1:0]    O_W_DATA,
	// status flags
	output logic                               O_FLAG_WE,
	output logic                               O_CARRY_FLAG,
	output logic                               O_DIGIT_CARRY_FLAG,
	output logic                               O_NEGATIVE_FLAG,
	output logic                               O_OVERFLOW_FLAG,
	output logic                               O_ZERO_FLAG,
	// sequencing status
	output logic      [1:0]                    O_Q_PHASE,
	output logic                               O_NOP_CYCLE,
	output logic                               O_FOREIGN_OP
);
	import bie_pkg::*;

	logic [1:0]         phase;
	bie_state_t         state;
	bie_state_t         next_state;
	bie_op_t            op;
	logic [WORD_W-1:0]  ir;
	logic               held_two_word;
	logic [LITLO_W-1:0] lit_lo;
	logic [DATA_W-1:0]  operand;
	logic [DATA_W-1:0]  result;
	logic [4:0]         flags;
	logic [PC_W-1:0]    pc;
	logic               nop_cycle;

	logic [DATA_W-1:0]  alu_result;
	logic               alu_c;
	logic               alu_dc;
	logic               alu_n;
	logic               alu_ov;
	logic               alu_z;

	// phase strobes
	wire end_q1 = (phase == PH_Q1);
	wire end_q2 = (phase == PH_Q2);
	wire end_q3 = (phase == PH_Q3);
	wire end_q4 = (phase == PH_Q4);
	wire exec   = (state == ST_EXEC);

	// decode of the word presented in Q1
	wire bie_op_t     dec_op     = exec ? decode_op(I_INSTR_WORD) : OP_NONE;
	wire              dec_family = (dec_op == OP_INC) ||
		(dec_op == OP_INCSZ) || (dec_op == OP_INCSNZ);
	wire [ADDR_W-1:0] dec_addr   = file_addr(I_INSTR_WORD[FADDR_W-1:0],
		I_INSTR_WORD[BANK_BIT], I_EXT_ISA_EN,
		I_BANK_SELECT, I_INDEX_BASE); // [RULE6] [RULE7]

	wire op_family = (op == OP_INC) || (op == OP_INCSZ) || (op == OP_INCSNZ);
	wire to_file   = ir[DEST_BIT];
	wire res_zero  = (result == 8'h00);
	wire take_skip = ((op == OP_INCSZ) && res_zero) || // [RULE8]
		((op == OP_INCSNZ) && !res_zero); // [RULE9]

	// second word supplies literal 19:8, pc bit 0 stays clear
	wire [LIT_W-1:0] branch_lit    = {I_NEXT_WORD[LITHI_W-1:0], lit_lo};
	wire [PC_W-1:0]  branch_target = {branch_lit, 1'b0}; // [RULE1] [RULE2]

	always_comb begin
		next_state = ST_EXEC;
		unique case (state)
			ST_EXEC: begin
				if (op == OP_BRANCH) begin
					next_state = ST_BRNOP; // [RULE3]
				end else if (take_skip) begin
					next_state = ST_SKIP; // [RULE10]
				end
			end
			ST_SKIP: begin
				if (held_two_word) begin
					next_state = ST_SKIP2; // [RULE11]
				end
			end
			ST_SKIP2: next_state = ST_EXEC;
			ST_BRNOP: next_state = ST_EXEC;
		endcase
	end

	// branch idle cycle holds pc: the target is already on the fetch port
	wire [PC_W-1:0] next_pc =
		(exec && (op == OP_BRANCH)) ? branch_target :
		(state == ST_BRNOP) ? pc : PC_W'(pc + PC_STEP);

	bie_inc_alu u_alu (
		.i_operand     (operand),
		.o_result      (alu_result),
		.o_carry       (alu_c),
		.o_digit_carry (alu_dc),
		.o_negative    (alu_n),
		.o_overflow    (alu_ov),
		.o_zero        (alu_z)
	);

	// quarter phase divider, one phase per clock
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			phase <= PH_Q1;
		end else begin
			phase <= phase + PH_STEP;
		end
	end

	// Q1 decode; nop cycles only note whether the discarded word is long
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			ir            <= 16'h0000;
			op            <= OP_NONE;
			held_two_word <= 1'b0;
			O_FOREIGN_OP  <= 1'b0;
		end else begin
			O_FOREIGN_OP <= 1'b0;
			if (end_q1) begin
				ir            <= I_INSTR_WORD;
				op            <= dec_op; // [RULE12]
				held_two_word <= is_two_word(I_INSTR_WORD); // [RULE11]
				O_FOREIGN_OP  <= exec && (dec_op == OP_NONE);
			end
		end
	end

	// Q2 register read: address goes out at the end of Q1, data back by Q2
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_DATA_ADDR <= 12'h000;
			O_DATA_RE   <= 1'b0;
			operand     <= 8'h00;
			lit_lo      <= 8'h00;
		end else begin
			O_DATA_RE <= 1'b0;
			if (end_q1 && dec_family) begin
				O_DATA_ADDR <= dec_addr;
				O_DATA_RE   <= 1'b1; // [RULE12]
			end
			if (end_q2) begin
				operand <= I_DATA_RDATA;
				lit_lo  <= ir[LITLO_W-1:0]; // [RULE1]
			end
		end
	end

	// Q3 process data
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			result <= 8'h00;
			flags  <= 5'h00;
		end else if (end_q3) begin
			result <= alu_result; // [RULE12]
			flags  <= {alu_c, alu_dc, alu_n, alu_ov, alu_z};
		end
	end

	// Q4 write destination; write strobes stand through the next Q1
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_DATA_WE    <= 1'b0;
			O_DATA_WDATA <= 8'h00;
			O_W_WE       <= 1'b0;
			O_W_DATA     <= 8'h00;
		end else begin
			O_DATA_WE <= 1'b0;
			O_W_WE    <= 1'b0;
			if (end_q4 && exec && op_family) begin
				O_DATA_WE    <= to_file; // [RULE5]
				O_DATA_WDATA <= result;
				O_W_WE       <= !to_file; // [RULE5]
				O_W_DATA     <= result;
			end
		end
	end

	// only the plain increment touches flags; skips and branch leave them
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			O_FLAG_WE          <= 1'b0;
			O_CARRY_FLAG       <= 1'b0;
			O_DIGIT_CARRY_FLAG <= 1'b0;
			O_NEGATIVE_FLAG    <= 1'b0;
			O_OVERFLOW_FLAG    <= 1'b0;
			O_ZERO_FLAG        <= 1'b0;
		end else begin
			O_FLAG_WE <= 1'b0;
			if (end_q4 && exec && (op == OP_INC)) begin
				O_FLAG_WE          <= 1'b1; // [RULE4]
				O_CARRY_FLAG       <= flags[4];
				O_DIGIT_CARRY_FLAG <= flags[3];
				O_NEGATIVE_FLAG    <= flags[2];
				O_OVERFLOW_FLAG    <= flags[1];
				O_ZERO_FLAG        <= flags[0];
			end
		end
	end

	// cycle boundary: sequencing state and program counter
	always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
		if (I_RST) begin
			state     <= ST_EXEC;
			pc        <= PC_RESET;
			nop_cycle <= 1'b0;
		end else if (end_q4) begin
			state     <= next_state;
			pc        <= next_pc; // [RULE1]
			nop_cycle <= (next_state != ST_EXEC); // [RULE10]
		end
	end

	assign O_PC        = pc;
	assign O_Q_PHASE   = phase;
	assign O_NOP_CYCLE = nop_cycle;
endmodule

// ===== common/bie_pkg.sv
// constants, types and decode helpers for the branch and increment executor
// assumes 16-bit program words and a 12-bit data address space
package bie_pkg;

	localparam int WORD_W  = 16;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 8;
	localparam int ADDR_W  = 12;
	localparam int BSR_W   = 4;
	localparam int PC_W    = 21;
	localparam int LIT_W   = 20;
	localparam int LITLO_W = 8;
	localparam int LITHI_W = 12;

	// operand field positions
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;

	// opcode patterns
	localparam logic [7:0] BRANCH_W1_OP = 8'hEF;
	localparam logic [3:0] BRANCH_W2_NIB = 4'hF;
	localparam logic [5:0] INC_OP       = 6'h0A;
	localparam logic [5:0] INCSZ_OP     = 6'h0F;
	localparam logic [5:0] INCSNZ_OP    = 6'h12;
	localparam logic [3:0] MOVE2_NIB    = 4'hC;
	localparam logic [6:0] CALL_OP7     = 7'h76;
	localparam logic [9:0] LOADPTR_OP10 = 10'h3B8;

	// data addressing
	localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
	localparam logic [7:0] INDEXED_MAX     = 8'h5F;
	localparam logic [3:0] ACCESS_SFR_BANK = 4'hF;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;

	// program counter
	localparam logic [20:0] PC_RESET = 21'h000000;
	localparam logic [20:0] PC_STEP  = 21'h000002;

	// quarter phases of one instruction cycle
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q2 = 2'h1;
	localparam logic [1:0] PH_Q3 = 2'h2;
	localparam logic [1:0] PH_Q4 = 2'h3;
	localparam logic [1:0] PH_STEP = 2'h1;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_BRANCH,
		OP_INC,
		OP_INCSZ,
		OP_INCSNZ
	} bie_op_t;

	typedef enum logic [1:0] {
		ST_EXEC,
		ST_SKIP,
		ST_SKIP2,
		ST_BRNOP
	} bie_state_t;

	function automatic bie_op_t decode_op(input logic [15:0] w);
		bie_op_t op;
		op = OP_NONE;
		if (w[15:8] == BRANCH_W1_OP) begin
			op = OP_BRANCH;
		end else if (w[15:10] == INC_OP) begin
			op = OP_INC;
		end else if (w[15:10] == INCSZ_OP) begin
			op = OP_INCSZ;
		end else if (w[15:10] == INCSNZ_OP) begin
			op = OP_INCSNZ;
		end
		return op;
	endfunction

	function automatic logic is_two_word(input logic [15:0] w);
		return (w[15:12] == MOVE2_NIB) || (w[15:9] == CALL_OP7) ||
			(w[15:8] == BRANCH_W1_OP) || (w[15:6] == LOADPTR_OP10);
	endfunction

	function automatic logic [11:0] file_addr(
		input logic [7:0]  f,
		input logic        bank,
		input logic        ext,
		input logic [3:0]  bank_select_register,
		input logic [11:0] base
	);
		logic [11:0] a;
		a = {bank_select_register, f};
		if (!bank) begin
			if (ext && (f <= INDEXED_MAX)) begin
				a = base + {4'h0, f};
			end else if (f < ACCESS_SPLIT) begin
				a = {ACCESS_LOW_BANK, f};
			end else begin
				a = {ACCESS_SFR_BANK, f};
			end
		end
		return a;
	endfunction

endpackage

// ===== rtl/bie_inc_alu.sv
// incrementer with status flag derivation for the increment family
// purely combinational; the caller registers the result in the process phase
`timescale 1ns/1ps
module bie_inc_alu (
	// operand
	input  wire logic [bie_pkg::DATA_W-1:0] i_operand,
	// result and flags
	output logic      [bie_pkg::DATA_W-1:0] o_result,
	output logic                            o_carry,
	output logic                            o_digit_carry,
	output logic                            o_negative,
	output logic                            o_overflow,
	output logic                            o_zero
);
	import bie_pkg::*;

	logic [DATA_W:0] sum;

	assign sum           = {1'b0, i_operand} + 9'h001;
	assign o_result      = sum[DATA_W-1:0];
	assign o_carry       = sum[DATA_W];
	assign o_digit_carry = (i_operand[3:0] == 4'hF);
	// only 7Fh crosses into the sign bit when adding one
	assign o_overflow    = (i_operand == 8'h7F);
	assign o_negative    = sum[DATA_W-1];
	assign o_zero        = (sum[DATA_W-1:0] == 8'h00);
endmodule

// ===== verif/bie_core_assertions.sv
// assertions on the executor's top ports
// bound to each bie_core; one clock domain, reset high
`timescale 1ns/1ps
module bie_core_assertions
	import bie_pkg::*;
(
	input wire logic        I_CLK_SYS,
	input wire logic        I_RST,
	input wire logic [20:0] O_PC,
	input wire logic [1:0]  O_Q_PHASE,
	input wire logic        O_NOP_CYCLE,
	input wire logic        O_DATA_RE,
	input wire logic        O_DATA_WE,
	input wire logic        O_W_WE,
	input wire logic        O_FLAG_WE,
	input wire logic        O_FOREIGN_OP,
	input wire logic [11:0] O_DATA_ADDR,
	input wire logic [7:0]  O_DATA_WDATA,
	input wire logic [7:0]  O_W_DATA,
	input wire logic        O_CARRY_FLAG,
	input wire logic        O_DIGIT_CARRY_FLAG,
	input wire logic        O_NEGATIVE_FLAG,
	input wire logic        O_OVERFLOW_FLAG,
	input wire logic        O_ZERO_FLAG
);
	default clocking @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_RST);
	wire logic [7:0] res = O_DATA_WE ? O_DATA_WDATA : O_W_DATA;
	read_q2_a:
		assert property (O_DATA_RE |-> O_Q_PHASE == PH_Q2)
		else $error("read outside second phase");
	write_after_read_a:
		assert property (O_DATA_RE |=> ($stable(O_DATA_ADDR))[*3]
		##0 (O_DATA_WE ^ O_W_WE) && O_Q_PHASE == PH_Q1)
		else $error("write missing after read");
	flag_values_a:
		assert property (O_FLAG_WE |-> {O_CARRY_FLAG, O_DIGIT_CARRY_FLAG,
		O_NEGATIVE_FLAG, O_OVERFLOW_FLAG, O_ZERO_FLAG} == {res == 8'h00,
		res[3:0] == 4'h0, res[7], res == 8'h80, res == 8'h00})
		else $error("flag values wrong");
	pc_at_q4_a:
		assert property (!$stable(O_PC) |-> $past(O_Q_PHASE) == PH_Q4)
		else $error("pc moved mid cycle");
	nop_whole_a:
		assert property (!$stable(O_NOP_CYCLE) |-> O_Q_PHASE == PH_Q1)
		else $error("nop flag moved mid cycle");
	nop_quiet_a:
		assert property (O_NOP_CYCLE |-> !O_DATA_RE && !O_FLAG_WE)
		else $error("activity in nop cycle");
	foreign_q2_a:
		assert property (O_FOREIGN_OP |-> O_Q_PHASE == PH_Q2 &&
		!O_DATA_RE && !O_NOP_CYCLE)
		else $error("foreign pulse misplaced");
	branch_hold_a:
		assert property (O_Q_PHASE == PH_Q1 && O_NOP_CYCLE &&
		!$past(O_NOP_CYCLE) && O_PC != $past(O_PC) + PC_STEP |=>
		(O_NOP_CYCLE && $stable(O_PC))[*3] ##1 !O_NOP_CYCLE && $stable(O_PC))
		else $error("branch idle cycle wrong");
	skip_step_a:
		assert property (O_Q_PHASE == PH_Q1 && O_NOP_CYCLE &&
		O_PC == $past(O_PC) + PC_STEP |-> ##4 O_PC == $past(O_PC, 4) + PC_STEP)
		else $error("skip pc step wrong");
endmodule
bind bie_core bie_core_assertions u_chk (.I_CLK_SYS(I_CLK_SYS),
	.I_RST(I_RST), .O_PC(O_PC), .O_Q_PHASE(O_Q_PHASE),
	.O_NOP_CYCLE(O_NOP_CYCLE), .O_DATA_RE(O_DATA_RE), .O_DATA_WE(O_DATA_WE),
	.O_W_WE(O_W_WE), .O_FLAG_WE(O_FLAG_WE), .O_FOREIGN_OP(O_FOREIGN_OP),
	.O_DATA_ADDR(O_DATA_ADDR), .O_DATA_WDATA(O_DATA_WDATA),
	.O_W_DATA(O_W_DATA), .O_CARRY_FLAG(O_CARRY_FLAG),
	.O_DIGIT_CARRY_FLAG(O_DIGIT_CARRY_FLAG),
	.O_NEGATIVE_FLAG(O_NEGATIVE_FLAG), .O_OVERFLOW_FLAG(O_OVERFLOW_FLAG),
	.O_ZERO_FLAG(O_ZERO_FLAG));

// ===== verif/bie_mem_model.sv
// program and data memory facing the executor
// program words indexed by pc bits 5:1; data read is combinational
`timescale 1ns/1ps
module bie_mem_model (
	// clock
	input  wire logic        i_clk,
	// program side
	input  wire logic [20:0] i_pc,
	output logic      [15:0] o_instr,
	output logic      [15:0] o_next,
	// data side
	input  wire logic [11:0] i_addr,
	input  wire logic        i_re,
	input  wire logic        i_we,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata
);
	logic [15:0] pmem [32];
	logic [7:0]  dmem [4096];
	wire  [4:0]  widx = i_pc[5:1];
	assign o_instr = pmem[widx];
	assign o_next = pmem[widx + 5'h01];
	// idle bus shows the inverse so a late sample cannot pass
	assign o_rdata = i_re ? dmem[i_addr] : ~dmem[i_addr];
	always @(posedge i_clk) begin
		if (i_we) begin
			dmem[i_addr] <= i_wdata;
		end
	end
endmodule

// ===== verif/testbench.sv
// runs a short program through bie_core and checks each cycle
// memories come from bie_mem_model; inputs change on falling edges
`timescale 1ns/1ps
module testbench;
	import bie_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ext = 1'b1;
	logic [3:0]  bank_select_register = 4'h2;
	logic [11:0] base = 12'h100;
	logic [15:0] ins, nxt;
	logic [20:0] pc;
	logic [11:0] adr;
	logic [7:0]  rd, wd, wdat;
	logic [1:0]  ph;
	logic        re, we, wwe, fwe, nop, fo, cf, dcf, nf, of, zf;
	int          errors = 0;
	int          samples_checked = 0;
	int          foreign = 0;
	localparam logic [15:0] PROG [15] = '{16'h2B10, 16'h2820, 16'h3E70,
		16'hC000, 16'hF000, 16'h4805, 16'h0000, 16'hEF0A, 16'hF000,
		16'h2B00, 16'h0000, 16'h4B11, 16'h3F12, 16'hEF0D, 16'hF000};
	bie_core dut (.I_CLK_SYS(clk), .I_RST(rst), .I_INSTR_WORD(ins),
		.I_NEXT_WORD(nxt), .O_PC(pc), .I_EXT_ISA_EN(ext),
		.I_BANK_SELECT(bank_select_register), .I_INDEX_BASE(base), .O_DATA_ADDR(adr),
		.O_DATA_RE(re), .I_DATA_RDATA(rd), .O_DATA_WE(we),
		.O_DATA_WDATA(wd), .O_W_WE(wwe), .O_W_DATA(wdat), .O_FLAG_WE(fwe),
		.O_CARRY_FLAG(cf), .O_DIGIT_CARRY_FLAG(dcf), .O_NEGATIVE_FLAG(nf),
		.O_OVERFLOW_FLAG(of), .O_ZERO_FLAG(zf), .O_Q_PHASE(ph),
		.O_NOP_CYCLE(nop), .O_FOREIGN_OP(fo));
	bie_mem_model mem (.i_clk(clk), .i_pc(pc), .o_instr(ins), .o_next(nxt),
		.i_addr(adr), .i_re(re), .i_we(we), .i_wdata(wd), .o_rdata(rd));
	always #20 clk = ~clk;
	always @(negedge clk) begin
		if (fo === 1'b1) foreign++;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	// next first-phase falling edge; s is {nop, file we, w we, flag we}
	task automatic chk(input logic [20:0] p, input logic [3:0] s,
		input logic [4:0] f, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ph !== PH_Q1 && n < 8);
		cmp(32'(pc), 32'(p));
		cmp(32'({nop, we, wwe, fwe}), 32'(s));
		if (s[0]) cmp(32'({cf, dcf, nf, of, zf}), 32'(f));
		if (s[2]) cmp(32'({adr, wd}), 32'({a, d}));
		if (s[1]) cmp(32'(wdat), 32'(d));
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 32; i++) begin
			mem.pmem[i] = (i < 15) ? PROG[i] : 16'h0000;
		end
		mem.dmem[12'h210] = 8'h7F;
		mem.dmem[12'h120] = 8'hFF;
		mem.dmem[12'hF70] = 8'hFF;
		mem.dmem[12'h105] = 8'h01;
		mem.dmem[12'h211] = 8'hFF;
		mem.dmem[12'h212] = 8'h05;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk(21'h02, 4'b0101, 5'h0E, 12'h210, 8'h80);
		chk(21'h04, 4'b0011, 5'h19, 12'h000, 8'h00);
		chk(21'h06, 4'b1100, 5'h00, 12'hF70, 8'h00);
		chk(21'h08, 4'b1000, 5'h00, 12'h000, 8'h00);
		chk(21'h0A, 4'b0000, 5'h00, 12'h000, 8'h00);
		chk(21'h0C, 4'b1010, 5'h00, 12'h000, 8'h02);
		chk(21'h0E, 4'b0000, 5'h00, 12'h000, 8'h00);
		chk(21'h14, 4'b1000, 5'h00, 12'h000, 8'h00);
		chk(21'h14, 4'b0000, 5'h00, 12'h000, 8'h00);
		chk(21'h16, 4'b0000, 5'h00, 12'h000, 8'h00);
		chk(21'h18, 4'b0100, 5'h00, 12'h211, 8'h00);
		chk(21'h1A, 4'b0100, 5'h00, 12'h212, 8'h06);
		chk(21'h1A, 4'b1000, 5'h00, 12'h000, 8'h00);
		cmp(32'(foreign), 32'h1);
		$display("program sequence done");
		test_done();
	end
	// the program needs about 60 clocks
	initial begin
		repeat (400) @(posedge clk);
		errors++;
		test_done();
	end
endmodule
